// [pkg/pdwu_pkg.sv]
/*
 * pdwu_pkg: constants, register map and state type of the power-down,
 * wake-up and supply monitor controller.
 * assumes a 200 MHz clock that keeps running while the core clock is gated.
 */
package pdwu_pkg;

    // ==========================================================
    // widths
    localparam int PORT_W = 8;
    localparam int IRQ_N  = 4;
    localparam int FLAG_N = IRQ_N + 1;
    localparam int SYNC_W = PORT_W + 2;
    localparam int CNT_W  = 12;
    localparam int ADDR_W = 12;

    // ==========================================================
    // timing
    localparam int CLOCK_PERIOD_PS          = 5000;
    localparam int MONITOR_SETTLE_TIME_NS   = 1000;
    localparam int MONITOR_IRQ_DELAY_NS     = 15000;
    localparam logic [CNT_W-1:0] SETTLE_CYCLES =
        CNT_W'((MONITOR_SETTLE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
    localparam logic [CNT_W-1:0] IRQ_DELAY_CYCLES =
        CNT_W'((MONITOR_IRQ_DELAY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFF_MON_CTRL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS     = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_WAKE_EN    = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_WAKE_CAUSE = 12'h00c;

    // ==========================================================
    // fields
    localparam int MC_SEL_LSB   = 0;
    localparam int MC_SEL_W     = 3;
    localparam int MC_EN_BIT    = 4;
    localparam int MC_OUT_BIT   = 5;
    localparam int ST_PDF_BIT   = 0;
    localparam int ST_TO_BIT    = 1;
    localparam int ST_LVF_BIT   = 2;
    localparam int ST_SLEEP_BIT = 3;
    localparam int CAUSE_EXT    = 0;
    localparam int CAUSE_WDT    = 1;
    localparam int CAUSE_IRQ    = 2;
    localparam int CAUSE_PORT   = 3;
    localparam int CAUSE_W      = 4;
    localparam int SYNC_EXT     = PORT_W;
    localparam int SYNC_LOW     = PORT_W + 1;

    // ==========================================================
    // reset values
    localparam logic [MC_SEL_W-1:0] SEL_RESET   = 3'h0;
    localparam logic [SYNC_W-1:0]   SYNC_RESET  = 10'h1ff;
    localparam logic [PORT_W-1:0]   WAKE_EN_RESET = 8'h00;
    localparam logic [CAUSE_W-1:0]  CAUSE_RESET = 4'h0;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE  = 3'b100
    } pdwu_state_t;

endpackage

// [hw/pdwu_ctrl.sv]
/*
 * pdwu_ctrl: power-down entry, wake-up arbitration, status flags and the
 * digital side of the supply monitor, with an APB register slave.
 * assumes clock keeps running during sleep; the core clock is gated by
 * sys_clock_run. pins and the comparator output are asynchronous.
 */
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module pdwu_ctrl
    import pdwu_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                resetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                halt_exec,
    input  wire logic                clr_wdt_exec,
    input  wire logic                ext_reset_n,
    input  wire logic [PORT_W-1:0]   port_a,
    input  wire logic [IRQ_N-1:0]    irq_flags,
    input  wire logic [FLAG_N-1:0]   irq_enable,
    input  wire logic                stack_full,
    input  wire logic                wdt_overflow,
    input  wire logic                wdt_enable,
    input  wire logic                wdt_from_sub,
    input  wire logic                low_supply_raw,
    output logic                     sys_clock_run,
    output logic                     cpu_halted,
    output logic                     hold_state,
    output logic                     wdt_clear,
    output logic                     wdt_run,
    output logic                     full_reset,
    output logic                     wdt_reset,
    output logic                     resume_next,
    output logic                     irq_vector,
    output logic                     monitor_on,
    output logic [MC_SEL_W-1:0]      threshold_select,
    output logic                     low_supply_irq_flag
);

    // ==========================================================
    // functions
    function automatic logic [SYNC_W-1:0] agree_filter(input logic [SYNC_W-1:0] s2,
                                                       input logic [SYNC_W-1:0] s3,
                                                       input logic [SYNC_W-1:0] old);
        agree_filter = (s2 & s3) | (old & (s2 | s3));
    endfunction

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] cnt,
                                                 input logic [CNT_W-1:0] top);
        sat_inc = (cnt == top) ? cnt : cnt + CNT_ONE;
    endfunction

    // ==========================================================
    // declarations
    pdwu_state_t         state_q;
    logic [SYNC_W-1:0]   sync1_q;
    logic [SYNC_W-1:0]   sync2_q;
    logic [SYNC_W-1:0]   sync3_q;
    logic [SYNC_W-1:0]   filt_q;
    logic [PORT_W-1:0]   port_prev_q;
    logic [FLAG_N-1:0]   flags_prev_q;
    logic [FLAG_N-1:0]   armed_q;
    logic [MC_SEL_W-1:0] sel_q;
    logic                mon_en_q;
    logic [CNT_W-1:0]    settle_cnt_q;
    logic [CNT_W-1:0]    delay_cnt_q;
    logic                out_flag_q;
    logic                lvf_q;
    logic                pdf_q;
    logic                to_q;
    logic [PORT_W-1:0]   wake_en_q;
    logic [CAUSE_W-1:0]  cause_q;
    logic [CAUSE_W-1:0]  cause_d;
    logic                vector_d;
    logic [31:0]         prdata_q;
    logic                pready_q;
    logic                pslverr_q;
    logic                sys_clock_run_q;
    logic                hold_state_q;
    logic                wdt_clear_q;
    logic                wdt_run_q;
    logic                full_reset_q;
    logic                wdt_reset_q;
    logic                resume_next_q;
    logic                irq_vector_q;
    logic                monitor_on_q;

    logic                setup;
    logic                wr_en;
    logic                addr_ok;
    logic                halt_ok;
    logic                settled;
    logic                lvf_set;
    logic [FLAG_N-1:0]   flags_now;
    logic [FLAG_N-1:0]   irq_rise;
    logic [PORT_W-1:0]   port_fall;
    logic                wake_any;

    // ==========================================================
    // pin synchroniser
    // three-stage sync, change taken when stages two and three agree
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sync1_q <= SYNC_RESET;
            sync2_q <= SYNC_RESET;
            sync3_q <= SYNC_RESET;
            filt_q  <= SYNC_RESET;
        end else begin
            sync1_q <= {low_supply_raw, ext_reset_n, port_a};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            filt_q  <= agree_filter(sync2_q, sync3_q, filt_q);
        end
    end

    // ==========================================================
    // wake detection
    assign flags_now = {lvf_q, irq_flags};
    // rising flag wakes whatever the enable bits say
    assign irq_rise  = flags_now & ~flags_prev_q & armed_q;
    // enabled pins wake on a falling edge
    assign port_fall = port_prev_q & ~filt_q[PORT_W-1:0] & wake_en_q;
    assign wake_any  = !filt_q[SYNC_EXT] || wdt_overflow || (|irq_rise) || (|port_fall);
    // only the instruction strobe, only while running
    assign halt_ok   = halt_exec && (state_q == ST_RUN);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            port_prev_q  <= SYNC_RESET[PORT_W-1:0];
            flags_prev_q <= '0;
            armed_q      <= '0;
        end else begin
            port_prev_q  <= filt_q[PORT_W-1:0];
            flags_prev_q <= flags_now;
            // a flag already high at entry is not armed
            // software presetting the low supply flag blocks its wake
            if (halt_ok) begin
                armed_q <= ~flags_now;
            end
        end
    end

    // wake priority: reset, watchdog, interrupt, port
    always_comb begin
        cause_d  = CAUSE_RESET;
        vector_d = 1'b0;
        if (!filt_q[SYNC_EXT]) begin
            cause_d[CAUSE_EXT] = 1'b1;
        end else if (wdt_overflow) begin
            cause_d[CAUSE_WDT] = 1'b1;
        end else if (|irq_rise) begin
            cause_d[CAUSE_IRQ] = 1'b1;
            // enabled and stack free vectors; otherwise resume
            vector_d = (|(irq_rise & irq_enable)) && !stack_full;
        end else begin
            cause_d[CAUSE_PORT] = 1'b1;
        end
    end

    // ==========================================================
    // power state machine
    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_q <= ST_RUN;
            cause_q <= CAUSE_RESET;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (halt_ok) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_any) begin
                        state_q <= ST_WAKE;
                        cause_q <= cause_d;
                    end
                end
                ST_WAKE: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // core clock gated from entry until wake; state held meanwhile
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sys_clock_run_q <= 1'b1;
            hold_state_q    <= 1'b0;
        end else begin
            if (halt_ok) begin
                sys_clock_run_q <= 1'b0;
                hold_state_q    <= 1'b1;
            end else if (state_q == ST_SLEEP && wake_any) begin
                sys_clock_run_q <= 1'b1;
                hold_state_q    <= 1'b0;
            end
        end
    end

    // resume pulses are issued in the wake cycle, clock already restarted
    always_ff @(posedge clock) begin
        if (!resetn) begin
            full_reset_q  <= 1'b0;
            wdt_reset_q   <= 1'b0;
            resume_next_q <= 1'b0;
            irq_vector_q  <= 1'b0;
        end else begin
            full_reset_q  <= 1'b0;
            wdt_reset_q   <= 1'b0;
            resume_next_q <= 1'b0;
            irq_vector_q  <= 1'b0;
            if (state_q == ST_SLEEP && wake_any) begin
                full_reset_q  <= cause_d[CAUSE_EXT];
                // watchdog wake resets only PC and SP
                wdt_reset_q   <= cause_d[CAUSE_WDT];
                resume_next_q <= cause_d[CAUSE_PORT] || (cause_d[CAUSE_IRQ] && !vector_d);
                irq_vector_q  <= vector_d;
            end
        end
    end

    // ==========================================================
    // watchdog control
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wdt_clear_q <= 1'b0;
            wdt_run_q   <= 1'b0;
        end else begin
            // clear on entry; run in sleep only from the sub clock
            wdt_clear_q <= halt_ok;
            if (halt_ok || state_q == ST_SLEEP) begin
                wdt_run_q <= wdt_enable && wdt_from_sub;
            end else begin
                wdt_run_q <= wdt_enable;
            end
        end
    end

    // ==========================================================
    // status flags
    always_ff @(posedge clock) begin
        if (!resetn) begin
            pdf_q <= 1'b0;
            to_q  <= 1'b0;
        end else begin
            // set by power-down wins over clear-watchdog
            if (halt_ok) begin
                pdf_q <= 1'b1;
            end else if (clr_wdt_exec) begin
                pdf_q <= 1'b0;
            end
            // timeout set wins over the clear at power-down
            if (wdt_overflow) begin
                to_q <= 1'b1;
            end else if (halt_ok) begin
                to_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // supply monitor
    assign settled = (settle_cnt_q == SETTLE_CYCLES);
    assign lvf_set = out_flag_q && (delay_cnt_q == IRQ_DELAY_CYCLES - CNT_ONE);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            settle_cnt_q <= '0;
            delay_cnt_q  <= '0;
            out_flag_q   <= 1'b0;
            monitor_on_q <= 1'b0;
        end else begin
            // monitor follows its enable, sleeping or not
            monitor_on_q <= mon_en_q;
            // settle count; output masked until settled, so an early read gives 0
            if (!mon_en_q) begin
                settle_cnt_q <= '0;
            end else begin
                settle_cnt_q <= sat_inc(settle_cnt_q, SETTLE_CYCLES);
            end
            // flag high while supply below threshold
            out_flag_q <= mon_en_q && settled && filt_q[SYNC_LOW];
            // delay count of continuous low supply
            if (!out_flag_q) begin
                delay_cnt_q <= '0;
            end else begin
                delay_cnt_q <= sat_inc(delay_cnt_q, IRQ_DELAY_CYCLES);
            end
        end
    end

    // ==========================================================
    // apb slave
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pready_q && pwrite && !pslverr_q;
    assign addr_ok = (paddr == OFF_MON_CTRL) || (paddr == OFF_STATUS) ||
                     (paddr == OFF_WAKE_EN) || (paddr == OFF_WAKE_CAUSE);

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_ok;
            if (setup && !pwrite) begin
                prdata_q <= '0;
                case (paddr)
                    OFF_MON_CTRL: begin
                        prdata_q[MC_SEL_LSB +: MC_SEL_W] <= sel_q;
                        prdata_q[MC_EN_BIT]  <= mon_en_q;
                        prdata_q[MC_OUT_BIT] <= out_flag_q;
                    end
                    OFF_STATUS: begin
                        prdata_q[ST_PDF_BIT]   <= pdf_q;
                        prdata_q[ST_TO_BIT]    <= to_q;
                        prdata_q[ST_LVF_BIT]   <= lvf_q;
                        prdata_q[ST_SLEEP_BIT] <= hold_state_q;
                    end
                    OFF_WAKE_EN: begin
                        prdata_q[PORT_W-1:0] <= wake_en_q;
                    end
                    OFF_WAKE_CAUSE: begin
                        prdata_q[CAUSE_W-1:0] <= cause_q;
                    end
                    default: begin
                        prdata_q <= '0;
                    end
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge clock) begin
        if (!resetn) begin
            sel_q     <= SEL_RESET;
            mon_en_q  <= 1'b0;
            wake_en_q <= WAKE_EN_RESET;
        end else if (wr_en) begin
            if (paddr == OFF_MON_CTRL) begin
                sel_q    <= pwdata[MC_SEL_LSB +: MC_SEL_W];
                mon_en_q <= pwdata[MC_EN_BIT];
            end
            if (paddr == OFF_WAKE_EN) begin
                wake_en_q <= pwdata[PORT_W-1:0];
            end
        end
    end

    // low supply irq flag: hardware set wins over a software write
    always_ff @(posedge clock) begin
        if (!resetn) begin
            lvf_q <= 1'b0;
        end else begin
            // raised after the delay; only software lowers it
            if (lvf_set) begin
                lvf_q <= 1'b1;
            end else if (wr_en && paddr == OFF_STATUS) begin
                lvf_q <= pwdata[ST_LVF_BIT];
            end
        end
    end

    // ==========================================================
    // outputs
    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign sys_clock_run       = sys_clock_run_q;
    assign cpu_halted          = hold_state_q;
    assign hold_state          = hold_state_q;
    assign wdt_clear           = wdt_clear_q;
    assign wdt_run             = wdt_run_q;
    assign full_reset          = full_reset_q;
    assign wdt_reset           = wdt_reset_q;
    assign resume_next         = resume_next_q;
    assign irq_vector          = irq_vector_q;
    assign monitor_on          = monitor_on_q;
    assign threshold_select    = sel_q;
    assign low_supply_irq_flag = lvf_q;

endmodule // pdwu_ctrl

// [tb/pdwu_ctrl_sva.sv]
/* pdwu_ctrl_sva: assertions on the ports of pdwu_ctrl.
   assumes a single clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module pdwu_ctrl_sva
    import pdwu_pkg::*;
(
    input logic                clock,
    input logic                resetn,
    input logic                psel,
    input logic                penable,
    input logic                pwrite,
    input logic [ADDR_W-1:0]   paddr,
    input logic [31:0]         pwdata,
    input logic                halt_exec,
    input logic                ext_reset_n,
    input logic                wdt_overflow,
    input logic                wdt_enable,
    input logic                wdt_from_sub,
    input logic                low_supply_raw,
    input logic                sys_clock_run,
    input logic                cpu_halted,
    input logic                hold_state,
    input logic                wdt_clear,
    input logic                wdt_run,
    input logic                full_reset,
    input logic                wdt_reset,
    input logic                resume_next,
    input logic                irq_vector,
    input logic                monitor_on,
    input logic [MC_SEL_W-1:0] threshold_select,
    input logic                low_supply_irq_flag
);
    // ====================
    // helpers
    logic [CNT_W-1:0] low_q;
    logic             sw_q;
    logic             wake_p;
    assign wake_p = full_reset | wdt_reset | resume_next | irq_vector;
    // saturating, so a long low-supply spell cannot wrap back to zero
    always_ff @(posedge clock) begin
        if (!resetn || !monitor_on || !low_supply_raw) begin
            low_q <= '0;
        end else if (low_q != '1) begin
            low_q <= low_q + CNT_ONE;
        end
    end
    // a software write may also set the flag; that rise is not timed
    always_ff @(posedge clock) begin
        sw_q <= psel && penable && pwrite && paddr == OFF_STATUS;
    end
    // ====================
    // properties
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_halt_taken;
        halt_exec && sys_clock_run && !wake_p;
    endsequence
    sequence s_ext_low;
        (!ext_reset_n && !sys_clock_run) [*4];
    endsequence
    a_halt_enters_sleep: assert property (s_halt_taken |=> !sys_clock_run && cpu_halted && wdt_clear)
        else $error("halt did not enter sleep");
    a_sleep_needs_halt: assert property ($fell(sys_clock_run) |-> $past(halt_exec))
        else $error("sleep without halt");
    a_sleep_holds_state: assert property (!sys_clock_run |-> hold_state && cpu_halted)
        else $error("state not held in sleep");
    a_wdt_run_entry: assert property ($fell(sys_clock_run) |-> wdt_run == ($past(wdt_enable) && $past(wdt_from_sub)))
        else $error("watchdog run wrong at entry");
    a_ext_full_reset: assert property (s_ext_low |-> ##[0:8] full_reset)
        else $error("external reset gave no full reset");
    a_wdt_wake_reset: assert property (!sys_clock_run && wdt_overflow && ext_reset_n |=> wdt_reset)
        else $error("watchdog wake gave no watchdog reset");
    a_wake_one_pulse: assert property (wake_p |-> $onehot({full_reset, wdt_reset, resume_next, irq_vector})
        && sys_clock_run ##1 !wake_p)
        else $error("wake pulse malformed");
    a_irq_flag_delay: assert property ($rose(low_supply_irq_flag) && !sw_q |-> low_q >= IRQ_DELAY_CYCLES)
        else $error("low supply flag raised early");
    a_irq_flag_late: assert property (low_q == IRQ_DELAY_CYCLES + SETTLE_CYCLES + 12'h010 |-> low_supply_irq_flag)
        else $error("low supply flag not raised");
    a_ctrl_write_field: assert property (psel && penable && pwrite && paddr == OFF_MON_CTRL
        |=> threshold_select == $past(pwdata[2:0]) ##1 monitor_on == $past(pwdata[MC_EN_BIT], 2))
        else $error("control fields not taken");
endmodule // pdwu_ctrl_sva

bind pdwu_ctrl pdwu_ctrl_sva u_sva (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .halt_exec,
    .ext_reset_n, .wdt_overflow, .wdt_enable, .wdt_from_sub, .low_supply_raw, .sys_clock_run, .cpu_halted,
    .hold_state, .wdt_clear, .wdt_run, .full_reset, .wdt_reset, .resume_next, .irq_vector, .monitor_on,
    .threshold_select, .low_supply_irq_flag
);

// [tb/test_pdwu_ctrl.sv]
/* test_pdwu_ctrl: self-checking bench for pdwu_ctrl.
   assumes pdwu_pkg and the bound checker; the bench drives every input. */
`timescale 1ns/1ps
module test_pdwu_ctrl
    import pdwu_pkg::*;
();
    // ====================
    // signals
    logic clock = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
    logic halt_exec = 1'h0, clr_wdt_exec = 1'h0, ext_reset_n = 1'h1, stack_full = 1'h0, wdt_overflow = 1'h0;
    logic wdt_enable = 1'h1, wdt_from_sub = 1'h1, low_supply_raw = 1'h0, sys_clock_run, cpu_halted;
    logic hold_state, wdt_clear, wdt_run, full_reset, wdt_reset, resume_next, irq_vector, monitor_on;
    logic low_supply_irq_flag;
    logic [ADDR_W-1:0]   paddr = 12'h000;
    logic [31:0]         pwdata = 32'h0, prdata, rd, d;
    logic [PORT_W-1:0]   port_a = 8'hff;
    logic [IRQ_N-1:0]    irq_flags = 4'h0;
    logic [FLAG_N-1:0]   irq_enable = 5'h00;
    logic [MC_SEL_W-1:0] threshold_select;
    logic [3:0]          wk;
    int                  miscompares = 0, n_checks = 0, seed = 32'h610a9c73;

    pdwu_ctrl uut (
        .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .halt_exec, .clr_wdt_exec, .ext_reset_n, .port_a, .irq_flags, .irq_enable, .stack_full,
        .wdt_overflow, .wdt_enable, .wdt_from_sub, .low_supply_raw, .sys_clock_run, .cpu_halted,
        .hold_state, .wdt_clear, .wdt_run, .full_reset, .wdt_reset, .resume_next, .irq_vector,
        .monitor_on, .threshold_select, .low_supply_irq_flag
    );

    always #2.5 clock = ~clock;

    // ====================
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] ctrl_exp(input logic [31:0] v, input logic o);
        return {26'h0, o, v[MC_EN_BIT], 1'h0, v[2:0]};
    endfunction
    // request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic halt;
        @(posedge clock);
        halt_exec <= 1'h1;
        @(posedge clock);
        halt_exec <= 1'h0;
        @(posedge clock);
        check(32'(sys_clock_run), 32'h0);
    endtask
    // returns {full reset, watchdog reset, vector, resume}, zero if none came
    task automatic wake(input int lim);
        wk = 4'h0;
        repeat (lim) begin
            @(posedge clock);
            if (full_reset | wdt_reset | irq_vector | resume_next) begin
                wk = {full_reset, wdt_reset, irq_vector, resume_next};
                break;
            end
        end
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude;
    end

    // ====================
    // scenarios
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'h1;
        apb(1'h0, OFF_MON_CTRL, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            apb(1'h1, OFF_MON_CTRL, {d[31:3], 3'(i)});
            apb(1'h0, OFF_MON_CTRL, 32'h0);
            check(rd, ctrl_exp({d[31:3], 3'(i)}, 1'h0));
            check(32'(threshold_select), 32'(i));
            check(32'(monitor_on), 32'(d[MC_EN_BIT]));
        end
        apb(1'h1, 12'h010, 32'hffffffff);
        check(32'(err), 32'h1);
        d = ($random(seed) & 32'h7f) | 32'h1;
        apb(1'h1, OFF_WAKE_EN, d);
        apb(1'h0, OFF_WAKE_EN, 32'h0);
        check(rd, d);
        halt;
        apb(1'h0, OFF_STATUS, 32'h0);
        check(rd, 32'h9);
        port_a[7] <= 1'h0;
        wake(30);
        check(32'(wk), 32'h0);
        port_a[0] <= 1'h0;
        wake(30);
        check(32'(wk), 32'h1);
        apb(1'h0, OFF_WAKE_CAUSE, 32'h0);
        check(rd, 32'h8);
        port_a <= 8'hff;
        irq_flags <= 4'h1;
        irq_enable <= 5'h02;
        halt;
        irq_flags <= 4'h0;
        @(posedge clock);
        irq_flags <= 4'h1;
        wake(30);
        check(32'(wk), 32'h0);
        irq_flags <= 4'h3;
        wake(20);
        check(32'(wk), 32'h2);
        for (int i = 0; i < 2; i++) begin
            irq_flags <= 4'h0;
            irq_enable <= 5'(i * 4);
            stack_full <= i[0];
            halt;
            irq_flags <= 4'h4;
            wake(20);
            check(32'(wk), 32'h1);
        end
        @(posedge clock);
        clr_wdt_exec <= 1'h1;
        @(posedge clock);
        clr_wdt_exec <= 1'h0;
        apb(1'h0, OFF_STATUS, 32'h0);
        check(rd, 32'h0);
        halt;
        check(32'(wdt_run), 32'h1);
        wdt_overflow <= 1'h1;
        @(posedge clock);
        wdt_overflow <= 1'h0;
        wake(20);
        check(32'(wk), 32'h4);
        apb(1'h0, OFF_STATUS, 32'h0);
        check(rd, 32'h3);
        wdt_from_sub <= 1'h0;
        halt;
        check(32'(wdt_run), 32'h0);
        ext_reset_n <= 1'h0;
        wake(30);
        check(32'(wk), 32'h8);
        ext_reset_n <= 1'h1;
        apb(1'h1, OFF_MON_CTRL, 32'h10);
        low_supply_raw <= 1'h1;
        repeat (3300) @(posedge clock);
        apb(1'h0, OFF_MON_CTRL, 32'h0);
        check(rd, ctrl_exp(32'h10, 1'h1));
        apb(1'h0, OFF_STATUS, 32'h0);
        check(rd, 32'h5);
        halt;
        wake(50);
        check(32'(wk), 32'h0);
        port_a[0] <= 1'h0;
        wake(30);
        check(32'(wk), 32'h1);
        port_a <= 8'hff;
        low_supply_raw <= 1'h0;
        repeat (8) @(posedge clock);
        apb(1'h1, OFF_STATUS, 32'h0);
        halt;
        low_supply_raw <= 1'h1;
        wake(3400);
        check(32'(wk), 32'h1);
        conclude;
    end
endmodule // test_pdwu_ctrl
